// File: rtl/urc_regs.vh
// Purpose: register map, field positions, bus response codes and serial format of the run-time control block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   definitions only
`ifndef URC_REGS_VH
`define URC_REGS_VH

`define URC_ADDR_CFG      8'h00
`define URC_ADDR_CTL      8'h04
`define URC_ADDR_STAT     8'h08
`define URC_ADDR_INTSTAT  8'h0C
`define URC_ADDR_INTEN    8'h10
`define URC_ADDR_INTCLR   8'h14
`define URC_ADDR_RXDAT    8'h18
`define URC_ADDR_TXDAT    8'h1C

`define URC_CFG_SYNC      0
`define URC_CTL_BRK       1
`define URC_CTL_ADDR      2
`define URC_CTL_HALT      6
`define URC_CTL_CONT      8
`define URC_CTL_ACLR      9

`define URC_STAT_RXRDY    0
`define URC_STAT_RXIDLE   1
`define URC_STAT_TXRDY    2
`define URC_STAT_TXIDLE   3
`define URC_STAT_HALTED   6

`define URC_INT_RX        0
`define URC_INT_HALT      6
`define URC_INT_W         7

`define URC_RESP_OKAY     2'b00
`define URC_RESP_SLVERR   2'b10

`define URC_DATA_BITS     9
`define URC_BIT_DIV       16
`define URC_ZERO_BIT      1'b0
`define URC_ONE_BIT       1'b1

`endif

// File: rtl/urc_tx.v
// Purpose: transmit shifter, start bit, data LSB first, one stop bit
// Assumes: start is a one-cycle pulse taken only while not busy
// Notes:   line rests high between characters
`timescale 1ns/1ps
`default_nettype none
`include "urc_regs.vh"
module urc_tx #(
  parameter DATA_W = `URC_DATA_BITS,
  parameter DIV    = `URC_BIT_DIV
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              start,
  input  wire [DATA_W-1:0] data,
  output reg               busy,
  output reg               line
);
  localparam [7:0] LAST_TICK = DIV - 1;
  localparam [4:0] LAST_BIT  = DATA_W + 1;

  reg [7:0]        tick;
  reg [4:0]        bitno;
  reg [DATA_W+1:0] shift;

  always @(posedge aclk) begin
    if (!aresetn) begin
      busy  <= 1'b0;
      line  <= 1'b1;
      tick  <= 8'h00;
      bitno <= 5'h00;
      shift <= {(DATA_W+2){1'b1}};
    end else if (!busy) begin
      if (start) begin
        busy  <= 1'b1;
        shift <= {`URC_ONE_BIT, data, `URC_ZERO_BIT};
        line  <= `URC_ZERO_BIT;
        tick  <= 8'h00;
        bitno <= 5'h00;
      end
    end else if (tick == LAST_TICK) begin
      tick <= 8'h00;
      if (bitno == LAST_BIT) begin
        busy <= 1'b0;
        line <= 1'b1;
      end else begin
        bitno <= bitno + 5'h01;
        shift <= {1'b1, shift[DATA_W+1:1]};
        line  <= shift[1];
      end
    end else begin
      tick <= tick + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: rtl/urc_rx.v
// Purpose: receive shifter, finds the start edge and samples mid-bit
// Assumes: rx is already synchronised to aclk
// Notes:   stop bit is sampled but not checked
`timescale 1ns/1ps
`default_nettype none
`include "urc_regs.vh"
module urc_rx #(
  parameter DATA_W = `URC_DATA_BITS,
  parameter DIV    = `URC_BIT_DIV
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              rx,
  output reg               busy,
  output reg               done,
  output reg  [DATA_W-1:0] data
);
  localparam [7:0] LAST_TICK = DIV - 1;
  localparam [7:0] HALF_TICK = DIV / 2;
  localparam [4:0] LAST_BIT  = DATA_W + 1;

  reg [7:0] tick;
  reg [4:0] bitno;

  always @(posedge aclk) begin
    if (!aresetn) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      data  <= {DATA_W{1'b0}};
      tick  <= 8'h00;
      bitno <= 5'h00;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (!rx) begin
          busy  <= 1'b1;
          tick  <= LAST_TICK - HALF_TICK;
          bitno <= 5'h00;
        end
      end else if (tick == LAST_TICK) begin
        tick <= 8'h00;
        if (bitno == 5'h00 && rx) begin
          // Glitch, not a start bit
          busy <= 1'b0;
        end else if (bitno == LAST_BIT) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          bitno <= bitno + 5'h01;
          if (bitno != 5'h00)
            data <= {rx, data[DATA_W-1:1]};
        end
      end else begin
        tick <= tick + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/urc_top.v
// Purpose: run-time control of a serial port: break, address filter, transmit halt, clock mode
// Assumes: AXI4-Lite slave on aclk, serial lines asynchronous to aclk
// Notes:   block drives the serial clock itself in synchronous mode
//
// What this block does
// - Setting break-send enable drives the transmit line low at once until it is cleared.
// - With address filtering off every received character reaches software.
// - With address filtering on only characters with MSB set are accepted and interrupt.
// - Software clears address filtering after a matching address, then all data passes.
// - Transmit halt lets the current character finish and then stops the transmitter.
// - In synchronous mode without continuous clock the serial clock runs only per character.
// - In synchronous mode with continuous clock the serial clock runs without pause.
// - Auto-clear drops continuous clock and itself once a full character is received.
// - The halted status and flag rise once the transmitter is idle after a halt request.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "urc_regs.vh"
module urc_top #(
  parameter DATA_W = `URC_DATA_BITS,
  parameter DIV    = `URC_BIT_DIV
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        receive_line,
  output reg         transmit_line,
  output reg         serial_clock,
  output reg         irq
);
  localparam [7:0] HALF_LAST = DIV / 2 - 1;

  // Control and configuration state
  reg              sync_mode;
  reg              break_send_enable;
  reg              address_filter_enable;
  reg              transmit_halt;
  reg              continuous_serial_clock;
  reg              auto_clear_continuous_clock;
  reg              transmit_halted_status;
  reg [`URC_INT_W-1:0] int_status;
  reg [`URC_INT_W-1:0] int_enable;
  reg              rx_ready;
  reg [DATA_W-1:0] rx_hold;
  reg              tx_pend;
  reg [DATA_W-1:0] tx_hold;

  // Write channel holding
  reg        aw_held;
  reg        w_held;
  reg [7:0]  wr_addr;
  reg [31:0] wr_data;
  reg [3:0]  wr_strb;

  // Receive line synchroniser
  reg rx_meta;
  reg rx_sync;

  // Serial clock generator
  reg [7:0] half_tick;

  wire              tx_busy;
  wire              tx_line;
  wire              rx_busy;
  wire              rx_done;
  wire [DATA_W-1:0] rx_data;

  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire do_read  = s_axi_arvalid && s_axi_arready;
  wire wr_ctl   = do_write && wr_addr == `URC_ADDR_CTL;
  wire wr_cfg   = do_write && wr_addr == `URC_ADDR_CFG;
  wire wr_inten = do_write && wr_addr == `URC_ADDR_INTEN;
  wire wr_clr   = do_write && wr_addr == `URC_ADDR_INTCLR;
  wire wr_tx    = do_write && wr_addr == `URC_ADDR_TXDAT;
  wire rd_rx    = do_read && s_axi_araddr == `URC_ADDR_RXDAT;

  wire tx_start = tx_pend && !transmit_halt && !break_send_enable && !tx_busy;

  wire rx_accept = rx_done && (!address_filter_enable || rx_data[DATA_W-1]);

  // In synchronous mode only: clock while a character moves, or always with continuous clock
  wire clock_run = sync_mode && (continuous_serial_clock || tx_busy || rx_busy);

  urc_tx #(
    .DATA_W (DATA_W),
    .DIV    (DIV)
  ) u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (tx_start),
    .data    (tx_hold),
    .busy    (tx_busy),
    .line    (tx_line)
  );

  urc_rx #(
    .DATA_W (DATA_W),
    .DIV    (DIV)
  ) u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rx      (rx_sync),
    .busy    (rx_busy),
    .done    (rx_done),
    .data    (rx_data)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= receive_line;
      rx_sync <= rx_meta;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `URC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (wr_addr)
          `URC_ADDR_CFG,
          `URC_ADDR_CTL,
          `URC_ADDR_INTEN,
          `URC_ADDR_INTCLR,
          `URC_ADDR_TXDAT: s_axi_bresp <= `URC_RESP_OKAY;
          default:         s_axi_bresp <= `URC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `URC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !do_read;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `URC_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (s_axi_araddr)
          `URC_ADDR_CFG: begin
            s_axi_rdata[`URC_CFG_SYNC] <= sync_mode;
          end
          `URC_ADDR_CTL: begin
            s_axi_rdata[`URC_CTL_BRK]  <= break_send_enable;
            s_axi_rdata[`URC_CTL_ADDR] <= address_filter_enable;
            s_axi_rdata[`URC_CTL_HALT] <= transmit_halt;
            s_axi_rdata[`URC_CTL_CONT] <= continuous_serial_clock;
            s_axi_rdata[`URC_CTL_ACLR] <= auto_clear_continuous_clock;
          end
          `URC_ADDR_STAT: begin
            s_axi_rdata[`URC_STAT_RXRDY]  <= rx_ready;
            s_axi_rdata[`URC_STAT_RXIDLE] <= !rx_busy;
            s_axi_rdata[`URC_STAT_TXRDY]  <= !tx_pend;
            s_axi_rdata[`URC_STAT_TXIDLE] <= !tx_busy;
            s_axi_rdata[`URC_STAT_HALTED] <= transmit_halted_status;
          end
          `URC_ADDR_INTSTAT: begin
            s_axi_rdata[`URC_INT_W-1:0] <= int_status;
          end
          `URC_ADDR_INTEN: begin
            s_axi_rdata[`URC_INT_W-1:0] <= int_enable;
          end
          `URC_ADDR_INTCLR,
          `URC_ADDR_TXDAT: begin
            s_axi_rdata <= 32'h0000_0000;
          end
          `URC_ADDR_RXDAT: begin
            s_axi_rdata[DATA_W-1:0] <= rx_hold;
          end
          default: begin
            s_axi_rresp <= `URC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control, configuration and interrupt enable registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_mode                   <= 1'b0;
      break_send_enable           <= 1'b0;
      address_filter_enable       <= 1'b0;
      transmit_halt               <= 1'b0;
      continuous_serial_clock     <= 1'b0;
      auto_clear_continuous_clock <= 1'b0;
      int_enable                  <= {`URC_INT_W{1'b0}};
    end else begin
      if (wr_cfg && wr_strb[0])
        sync_mode <= wr_data[`URC_CFG_SYNC];
      if (wr_inten && wr_strb[0])
        int_enable <= wr_data[`URC_INT_W-1:0];
      if (wr_ctl && wr_strb[0]) begin
        break_send_enable     <= wr_data[`URC_CTL_BRK];
        address_filter_enable <= wr_data[`URC_CTL_ADDR];
        transmit_halt         <= wr_data[`URC_CTL_HALT];
      end
      if (wr_ctl && wr_strb[1]) begin
        continuous_serial_clock     <= wr_data[`URC_CTL_CONT];
        auto_clear_continuous_clock <= wr_data[`URC_CTL_ACLR];
      end
      if (rx_done && auto_clear_continuous_clock) begin
        continuous_serial_clock     <= 1'b0;
        auto_clear_continuous_clock <= 1'b0;
      end
    end
  end

  // Transmit holding word
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_pend <= 1'b0;
      tx_hold <= {DATA_W{1'b0}};
    end else if (tx_start) begin
      tx_pend <= 1'b0;
    end else if (wr_tx && !tx_pend) begin
      // Write while full is dropped; software checks the ready bit first
      tx_pend <= 1'b1;
      tx_hold <= wr_data[DATA_W-1:0];
    end
  end

  // Receive holding word
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_ready <= 1'b0;
      rx_hold  <= {DATA_W{1'b0}};
    end else if (rx_accept) begin
      rx_ready <= 1'b1;
      rx_hold  <= rx_data;
    end else if (rd_rx) begin
      rx_ready <= 1'b0;
    end
  end

  // Halted status and sticky events
  always @(posedge aclk) begin
    if (!aresetn) begin
      transmit_halted_status <= 1'b0;
      int_status             <= {`URC_INT_W{1'b0}};
    end else begin
      // Halted one cycle after request when idle
      transmit_halted_status <= transmit_halt && !tx_busy;
      if (wr_clr && wr_strb[0])
        int_status <= int_status & ~wr_data[`URC_INT_W-1:0];
      // Flag on entry to halted state
      if (transmit_halt && !tx_busy && !transmit_halted_status)
        int_status[`URC_INT_HALT] <= 1'b1;
      if (rx_accept)
        int_status[`URC_INT_RX] <= 1'b1;
    end
  end

  // Serial outputs and interrupt
  always @(posedge aclk) begin
    if (!aresetn) begin
      transmit_line <= 1'b1;
      serial_clock  <= 1'b0;
      half_tick     <= 8'h00;
      irq           <= 1'b0;
    end else begin
      // Break overrides the shifter at once
      transmit_line <= break_send_enable ? `URC_ZERO_BIT : tx_line;
      irq           <= |(int_status & int_enable);
      if (!clock_run) begin
        // Clock parks low so the peer sees no stray edge between characters
        half_tick    <= 8'h00;
        serial_clock <= 1'b0;
      end else if (half_tick == HALF_LAST) begin
        half_tick    <= 8'h00;
        serial_clock <= !serial_clock;
      end else begin
        half_tick <= half_tick + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/urc_peer.sv
// Purpose: remote serial peer on the receive and transmit lines
// Assumes: start bit, 9 data bits LSB first, one stop bit, BIT_NS per bit
// Notes:   own timing, phase unrelated to aclk; lines rest high as with a pull-up
`timescale 1ns/1ps
`default_nettype none
module urc_peer #(
  parameter int BIT_NS = 800
) (
  output var logic receive_line,
  input  wire logic transmit_line
);
  logic [8:0] got_q[$];
  initial receive_line = 1'b1;
  task automatic send(input logic [8:0] c);
    #37;
    receive_line = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 9; i++) begin
      receive_line = c[i];
      #BIT_NS;
    end
    receive_line = 1'b1;
    #BIT_NS;
  endtask
  // Offset keeps mid-bit samples clear of the block's clock edges
  always begin : capture
    logic [8:0] c;
    @(negedge transmit_line);
    #(BIT_NS / 2 + 13);
    for (int i = 0; i < 9; i++) begin
      #BIT_NS;
      c[i] = transmit_line;
    end
    got_q.push_back(c);
    wait (transmit_line);
  end
endmodule
`default_nettype wire

// File: tb/urc_checker.sv
// Purpose: port checks of the run-time control block
// Assumes: DIV equals the instance value
// Notes:   control and configuration shadows trail the block by one cycle
`timescale 1ns/1ps
`default_nettype none
`include "urc_regs.vh"
module urc_checker #(
  parameter DIV = `URC_BIT_DIV
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        receive_line,
  input wire logic        transmit_line,
  input wire logic        serial_clock,
  input wire logic        irq
);
  localparam int SCK_MAX = DIV / 2 + 2;
  localparam int QUIET = 12 * DIV;
  logic [7:0]  wa;
  logic [7:0]  quiet;
  logic [31:0] wd;
  logic [31:0] ctl_sh;
  logic        bv_q;
  logic        sync_sh;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa <= 8'h00;
      wd <= 32'h00000000;
      ctl_sh <= 32'h00000000;
      sync_sh <= 1'b0;
      bv_q <= 1'b0;
      quiet <= 8'h00;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
      if (s_axi_bvalid && !bv_q && wa == `URC_ADDR_CTL) ctl_sh <= wd;
      if (s_axi_bvalid && !bv_q && wa == `URC_ADDR_CFG) sync_sh <= wd[0];
      // A full character of idle lines before the parked clock is judged
      if (!transmit_line || !receive_line || s_axi_bvalid) quiet <= 8'h00;
      else quiet <= quiet + {7'h00, quiet != 8'hFF};
    end
  end
  // Writable words answer OKAY; read-only, unaligned or unmapped ones refuse
  function automatic logic wr_mapped(input logic [7:0] a);
    return a == `URC_ADDR_CFG || a == `URC_ADDR_CTL || a == `URC_ADDR_INTEN ||
      a == `URC_ADDR_INTCLR || a == `URC_ADDR_TXDAT;
  endfunction
  function automatic logic rd_mapped(input logic [7:0] a);
    return a <= `URC_ADDR_TXDAT && a[1:0] == 2'b00;
  endfunction
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_idle: assert property ($rose(aresetn) |-> transmit_line && !serial_clock && !irq)
    else $error("outputs not idle after reset");
  chk_break_low: assert property (ctl_sh[`URC_CTL_BRK] |-> !transmit_line)
    else $error("transmit line high during break");
  chk_sck_cont: assert property (sync_sh && ctl_sh[8] && !ctl_sh[9] && !s_axi_bvalid
    |-> ##[1:SCK_MAX] $changed(serial_clock)) else $error("continuous clock paused");
  chk_sck_parked: assert property (sync_sh && !ctl_sh[8] && quiet >= QUIET |-> !serial_clock)
    else $error("serial clock runs while idle");
  chk_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_ready_drop: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write readys did not drop");
  chk_wr_resp: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (wr_mapped(wa) ? `URC_RESP_OKAY : `URC_RESP_SLVERR)) else $error("bad bresp");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid &&
    s_axi_rresp == (rd_mapped($past(s_axi_araddr)) ? `URC_RESP_OKAY : `URC_RESP_SLVERR))
    else $error("read answer wrong");
endmodule
bind urc_top urc_checker #(.DIV(DIV)) u_chk (.*);
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench of the run-time control block
// Assumes: DIV 8, so one bit lasts 800 ns at the 100 ns clock
// Notes:   expected characters come from the bench's own queue model
`timescale 1ns/1ps
`default_nettype none
`include "urc_regs.vh"
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic        receive_line, transmit_line, serial_clock, irq, flt, acc;
  logic [8:0]  c;
  logic [8:0]  exp_q[$];
  int          seed = 95, fails = 0, checks = 0, n;
  urc_top #(.DIV(8)) dut (.*);
  urc_peer peer (.receive_line(receive_line), .transmit_line(transmit_line));
  always #50 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    chk("write resp", r, `URC_RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e, input string nm);
    rd(a);
    chk(nm, d & m, e);
  endtask
  task automatic wait_peer();
    repeat (300) if (peer.got_q.size() == 0) @(posedge aclk);
    chk("peer chars", peer.got_q.size(), 1);
  endtask
  task automatic count_sck();
    logic last;
    last = serial_clock;
    n = 0;
    repeat (40) begin
      @(posedge aclk);
      n += (serial_clock !== last);
      last = serial_clock;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`URC_ADDR_CTL, 32'hFFFFFFFF, 32'h0, "ctl reset");
    rd_chk(`URC_ADDR_STAT, 32'hFFFFFFFF, 32'hE, "stat reset");
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped data");
    chk("unmapped read resp", r, `URC_RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk("unmapped write resp", r, `URC_RESP_SLVERR);
    // Upper byte lane off, so the continuous clock bit must not change
    s_axi_wstrb <= 4'h1;
    wr_ok(`URC_ADDR_CTL, 32'h100);
    s_axi_wstrb <= 4'hF;
    rd_chk(`URC_ADDR_CTL, 32'h100, 32'h0, "strobe gated");
    $display("test registers done");
    wr_ok(`URC_ADDR_INTEN, 32'h1);
    for (int k = 0; k < 4; k++) begin
      c = 9'($random(seed));
      if (k > 0) c[8] = (k == 2);
      flt = (k == 1 || k == 2);
      acc = !flt || c[8];
      // reserved bits zero, filter dropped after address
      wr_ok(`URC_ADDR_CTL, {29'h0, flt, 2'b00});
      if (acc) exp_q.push_back(c);
      peer.send(c);
      repeat (4) @(posedge aclk);
      chk("rx event", irq, acc);
      if (acc) rd_chk(`URC_ADDR_RXDAT, 32'h1FF, exp_q.pop_front(), "rx data");
      wr_ok(`URC_ADDR_INTCLR, 32'h1);
    end
    $display("test filter done");
    c = 9'($random(seed));
    wr_ok(`URC_ADDR_TXDAT, {23'h0, c});
    wr_ok(`URC_ADDR_CTL, 32'h40);
    rd_chk(`URC_ADDR_STAT, 32'h40, 32'h0, "halted while busy");
    wait_peer();
    chk("tx char", peer.got_q.pop_front(), c);
    repeat (24) @(posedge aclk);
    rd_chk(`URC_ADDR_STAT, 32'h40, 32'h40, "halted after char");
    chk("masked event", irq, 0);
    wr_ok(`URC_ADDR_INTEN, 32'h41);
    @(posedge aclk);
    chk("halt event", irq, 1);
    wr_ok(`URC_ADDR_INTCLR, 32'h40);
    @(posedge aclk);
    chk("event cleared", irq, 0);
    wr_ok(`URC_ADDR_CTL, 32'h42);
    repeat (4) begin
      repeat (5) @(posedge aclk);
      chk("break line", transmit_line, 0);
    end
    wr_ok(`URC_ADDR_CTL, 32'h40);
    @(posedge aclk);
    chk("line after break", transmit_line, 1);
    repeat (120) @(posedge aclk);
    peer.got_q.delete();
    wr_ok(`URC_ADDR_CTL, 32'h0);
    rd_chk(`URC_ADDR_STAT, 32'h40, 32'h0, "halt released");
    wr_ok(`URC_ADDR_CTL, 32'h40);
    rd_chk(`URC_ADDR_STAT, 32'h40, 32'h40, "idle halt");
    wr_ok(`URC_ADDR_INTCLR, 32'h40);
    wr_ok(`URC_ADDR_CTL, 32'h0);
    $display("test halt done");
    wr_ok(`URC_ADDR_CFG, 32'h1);
    wr_ok(`URC_ADDR_CTL, 32'h100);
    count_sck();
    chk("continuous clock", n >= 9, 1);
    wr_ok(`URC_ADDR_CTL, 32'h0);
    // Long idle so the parked-clock assertion is judged too
    repeat (100) @(posedge aclk);
    count_sck();
    chk("parked clock", n, 0);
    c = 9'($random(seed));
    wr_ok(`URC_ADDR_TXDAT, {23'h0, c});
    count_sck();
    chk("clock with char", n > 0, 1);
    wait_peer();
    chk("sync tx char", peer.got_q.pop_front(), c);
    repeat (100) @(posedge aclk);
    wr_ok(`URC_ADDR_CTL, 32'h300);
    c = 9'($random(seed));
    exp_q.push_back(c);
    peer.send(c);
    repeat (4) @(posedge aclk);
    rd_chk(`URC_ADDR_CTL, 32'h300, 32'h0, "auto clear");
    rd_chk(`URC_ADDR_RXDAT, 32'h1FF, exp_q.pop_front(), "sync rx data");
    $display("test sync done");
    give_verdict();
  end
endmodule
`default_nettype wire
